/* rtl/ilc_pkg.sv */
// Shared constants and carrier types for the interrupt and wake logic
package ilc_pkg;
    // Register addresses on the local port
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_OPTION = 3'h1;
    localparam logic [2:0] ADDR_REQ_A  = 3'h2;
    localparam logic [2:0] ADDR_REQ_B  = 3'h3;
    localparam logic [2:0] ADDR_EN_A   = 3'h4;
    localparam logic [2:0] ADDR_EN_B   = 3'h5;
    localparam logic [2:0] ADDR_STAT   = 3'h6;
    localparam logic [2:0] ADDR_TIMER  = 3'h7;
    // interrupt_control field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PGE_BIT       = 6;
    localparam int TOE_BIT       = 5;
    localparam int PIE_BIT       = 4;
    localparam int PCE_BIT       = 3;
    localparam int TOF_BIT       = 2;
    localparam int PIF_BIT       = 1;
    localparam int PCF_BIT       = 0;
    // Option and status field positions
    localparam int EDGE_BIT  = 6;
    localparam int TO_BIT    = 4;
    localparam int PWRDN_BIT = 3;
    // Reset values and timer maximum
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] REQ_RST    = 8'h00;
    localparam logic [7:0] TIMER_RST  = 8'h00;
    localparam logic [7:0] TIMER_MAX  = 8'hFF;
    // Program counter targets
    localparam int          PC_W      = 13;
    localparam logic [12:0] VEC_IRQ   = 13'h0004;
    localparam logic [12:0] VEC_RESET = 13'h0000;
    // Device reset causes
    typedef enum logic [1:0] {CAUSE_POR, CAUSE_BOR, CAUSE_EXT_RST, CAUSE_DOG} ilc_cause_type;
    // Requests from the processor core
    typedef struct packed {
        logic          irq_return;
        logic          take;
        logic          sleep;
        logic          dog_timeout;
        logic          dev_reset;
        ilc_cause_type cause;
        logic [12:0]   ret_addr;
    } ilc_core_req_type;
    // Answers to the processor core
    typedef struct packed {
        logic        pc_load;
        logic [12:0] pc_val;
        logic        push;
        logic [12:0] push_val;
    } ilc_core_rsp_type;
endpackage : ilc_pkg

/* rtl/ilc_irq_wake.sv */
// Interrupt control, pin and port-change detection, sleep and wake logic
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ilc_irq_wake
    import ilc_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // Register port
    input  wire logic [2:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Processor core
    input  ilc_core_req_type      core_req,
    output ilc_core_rsp_type      core_rsp,
    output logic                  irq_req,
    output logic                  wake_pulse,
    output logic                  asleep,
    // Interrupt sources
    input  wire logic             external_irq_pin,
    input  wire logic [7:4]       port_b_pins,
    input  wire logic             timer_tick,
    input  wire logic [1:0][7:0]  periph_evt
);

    typedef enum {ST_RUN, ST_SLEEP} ilc_state_type;

    ilc_state_type   st_q;
    logic [7:0]      ctrl_q;
    logic [7:0]      ctrl_d;
    logic [7:0]      option_q;
    logic [1:0][7:0] req_q;
    logic [1:0][7:0] en_q;
    logic [7:0]      timer_q;
    logic            to_q;
    logic            pwrdn_q;
    logic [2:0]      pin_q;
    logic [2:0][3:0] port_q;
    logic [2:0]      warm_q;
    logic            pin_edge;
    logic            port_chg;
    logic            tmr_ovf;
    logic            core_pend;
    logic            per_pend;
    logic            any_pend;

    // Write strobe decode for one address
    function automatic logic wr_hit(input logic [2:0] a);
        return reg_wr && (reg_addr == a);
    endfunction : wr_hit

    // Two-stage synchronisers plus one history stage
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_q  <= 3'h0;
            port_q <= '0;
            warm_q <= 3'h0;
        end else begin
            pin_q  <= {pin_q[1:0], external_irq_pin};
            port_q <= {port_q[1:0], port_b_pins};
            warm_q <= {warm_q[1:0], 1'b1};            // History valid after three edges
        end
    end

    // Edge and change detection, held off until the history stage is filled
    assign pin_edge = warm_q[2] & (option_q[EDGE_BIT] ? (pin_q[1] & ~pin_q[2])
                                                      : (~pin_q[1] & pin_q[2]));
    assign port_chg = warm_q[2] & (port_q[1] != port_q[2]);
    assign tmr_ovf  = timer_tick && (timer_q == TIMER_MAX);

    // Pending terms and request to the core
    assign core_pend = (ctrl_q[TOE_BIT] & ctrl_q[TOF_BIT])
                     | (ctrl_q[PIE_BIT] & ctrl_q[PIF_BIT])
                     | (ctrl_q[PCE_BIT] & ctrl_q[PCF_BIT]);
    assign per_pend  = |(req_q[0] & en_q[0]) | |(req_q[1] & en_q[1]);
    assign any_pend  = core_pend | (ctrl_q[PGE_BIT] & per_pend);
    assign irq_req   = ctrl_q[GLOBAL_EN_BIT] & any_pend & (st_q == ST_RUN);
    assign asleep    = st_q == ST_SLEEP;

    // Next value of interrupt_control
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_hit(ADDR_CTRL)) begin
            ctrl_d = reg_wdata;
        end
        if (core_req.take) begin
            ctrl_d[GLOBAL_EN_BIT] = 1'b0;
        end else if (core_req.irq_return) begin
            ctrl_d[GLOBAL_EN_BIT] = 1'b1;
        end
        if (core_req.dev_reset) begin
            ctrl_d = {CTRL_RST[7:1], ctrl_q[PCF_BIT]};
        end
        // Hardware set wins over a clearing write
        ctrl_d[PIF_BIT] = ctrl_d[PIF_BIT] | pin_edge;
        ctrl_d[TOF_BIT] = ctrl_d[TOF_BIT] | tmr_ovf;
        ctrl_d[PCF_BIT] = ctrl_d[PCF_BIT] | port_chg;
    end

    // interrupt_control register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Option register, edge select only is used here
    always_ff @(posedge core_clk) begin
        if (!rst_b || core_req.dev_reset) begin
            option_q <= OPTION_RST;
        end else if (wr_hit(ADDR_OPTION)) begin
            option_q <= reg_wdata;
        end
    end

    // Peripheral request and enable banks
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                req_q[b] <= REQ_RST;
                en_q[b]  <= REQ_RST;
            end else begin
                if (core_req.dev_reset) begin
                    req_q[b] <= periph_evt[b];
                    en_q[b]  <= REQ_RST;
                end else begin
                    req_q[b] <= (wr_hit(ADDR_REQ_A + 3'(b)) ? reg_wdata : req_q[b])
                              | periph_evt[b];
                    if (wr_hit(ADDR_EN_A + 3'(b))) begin
                        en_q[b] <= reg_wdata;
                    end
                end
            end
        end
    end

    // Eight-bit timer, wraps from FFh to 00h
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            timer_q <= TIMER_RST;
        end else if (wr_hit(ADDR_TIMER)) begin
            timer_q <= reg_wdata;
        end else if (timer_tick) begin
            timer_q <= timer_q + 8'h01;
        end
    end

    // Sleep state and wake pulse
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q       <= ST_RUN;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            case (st_q)
                ST_RUN: begin
                    // A pending enabled source turns sleep into a no-op
                    if (core_req.sleep && !core_req.dev_reset && !any_pend) begin
                        st_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (core_req.dev_reset) begin
                        st_q <= ST_RUN;
                    end else if (any_pend || core_req.dog_timeout) begin
                        st_q       <= ST_RUN;
                        wake_pulse <= 1'b1;
                    end
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    // Timeout and power-down status bits
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            to_q    <= 1'b1;
            pwrdn_q <= 1'b1;
        end else if (core_req.dev_reset) begin
            case (core_req.cause)
                CAUSE_POR, CAUSE_BOR: begin
                    to_q    <= 1'b1;
                    pwrdn_q <= 1'b1;
                end
                CAUSE_EXT_RST: begin
                    if (st_q == ST_SLEEP) begin
                        to_q    <= 1'b1;
                        pwrdn_q <= 1'b0;
                    end
                end
                CAUSE_DOG: begin
                    to_q    <= 1'b0;
                    pwrdn_q <= 1'b1;
                end
                default: begin
                    to_q    <= 1'b1;
                    pwrdn_q <= 1'b1;
                end
            endcase
        end else if (st_q == ST_SLEEP && core_req.dog_timeout && !any_pend) begin
            to_q    <= 1'b0;
            pwrdn_q <= 1'b0;
        end else if (st_q == ST_RUN && core_req.sleep && !any_pend) begin
            to_q    <= 1'b1;
            pwrdn_q <= 1'b0;
        end
    end

    // Program counter load and stack push towards the core
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            core_rsp <= '0;
        end else begin
            core_rsp.pc_load  <= core_req.dev_reset || core_req.take;
            core_rsp.pc_val   <= core_req.dev_reset ? VEC_RESET : VEC_IRQ;
            core_rsp.push     <= core_req.take && !core_req.dev_reset;
            core_rsp.push_val <= core_req.ret_addr;
        end
    end

    // Read data, valid in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL:   reg_rdata <= ctrl_q;
                ADDR_OPTION: reg_rdata <= option_q;
                ADDR_REQ_A:  reg_rdata <= req_q[0];
                ADDR_REQ_B:  reg_rdata <= req_q[1];
                ADDR_EN_A:   reg_rdata <= en_q[0];
                ADDR_EN_B:   reg_rdata <= en_q[1];
                ADDR_STAT:   reg_rdata <= {3'h0, to_q, pwrdn_q, 3'h0};
                ADDR_TIMER:  reg_rdata <= timer_q;
                default:     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    property p_flag_set;
        @(posedge core_clk) disable iff (!rst_b)
        periph_evt[0][3] |=> req_q[0][3];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");

    property p_enable_gate;
        @(posedge core_clk) disable iff (!rst_b)
        core_req.take || core_req.dev_reset |=> !irq_req;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("request after entry");

    property p_reset_enable;
        @(posedge core_clk) disable iff (!rst_b)
        core_req.dev_reset |=> !ctrl_q[GLOBAL_EN_BIT] && core_rsp.pc_load
            && core_rsp.pc_val == VEC_RESET;
    endproperty
    a_reset_enable: assert property (p_reset_enable) else $error("reset left enable");

    property p_irq_return;
        @(posedge core_clk) disable iff (!rst_b)
        core_req.irq_return && !core_req.take && !core_req.dev_reset
            |=> ctrl_q[GLOBAL_EN_BIT];
    endproperty
    a_irq_return: assert property (p_irq_return) else $error("return did not enable");

    property p_take;
        @(posedge core_clk) disable iff (!rst_b)
        core_req.take && !core_req.dev_reset |=> !ctrl_q[GLOBAL_EN_BIT] && core_rsp.push
            && core_rsp.pc_load && core_rsp.pc_val == VEC_IRQ
            && core_rsp.push_val == $past(core_req.ret_addr);
    endproperty
    a_take: assert property (p_take) else $error("entry sequence wrong");

    property p_latency;
        @(posedge core_clk) disable iff (!rst_b)
        pin_edge && ctrl_q[PIE_BIT] && ctrl_q[GLOBAL_EN_BIT] && st_q == ST_RUN && !core_req.sleep
            && !core_req.take && !core_req.dev_reset && !wr_hit(ADDR_CTRL) |=> irq_req;
    endproperty
    a_latency: assert property (p_latency) else $error("pin request late");

    property p_edge;
        @(posedge core_clk) disable iff (!rst_b)
        warm_q[2] && pin_q[1] && !pin_q[2] && option_q[EDGE_BIT] |=> ctrl_q[PIF_BIT];
    endproperty
    a_edge: assert property (p_edge) else $error("rising edge missed");

    property p_timer;
        @(posedge core_clk) disable iff (!rst_b)
        timer_tick && timer_q == TIMER_MAX && !wr_hit(ADDR_TIMER)
            |=> timer_q == TIMER_RST && ctrl_q[TOF_BIT];
    endproperty
    a_timer: assert property (p_timer) else $error("timer wrap missed");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_b)
        st_q == ST_SLEEP && any_pend && !core_req.dev_reset
            |=> wake_pulse && st_q == ST_RUN && to_q && !pwrdn_q;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");

    property p_dog_wake;
        @(posedge core_clk) disable iff (!rst_b)
        st_q == ST_SLEEP && core_req.dog_timeout && !any_pend && !core_req.dev_reset
            |=> !to_q && !pwrdn_q && !core_rsp.pc_load;
    endproperty
    a_dog_wake: assert property (p_dog_wake) else $error("watchdog wake status");

endmodule : ilc_irq_wake

/* verif/ilc_core_model.sv */
// Behavioural processor core facing the interrupt and wake logic
`timescale 1ns/1ps
module ilc_core_model
    import ilc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Interrupt side
    input  wire logic       irq_req,
    input  wire logic [3:0] take_lag,
    output ilc_core_req_type core_req
);
    int            wait_cnt = 0;
    logic          take_q   = 1'b0;
    logic [3:0]    pulse_q  = 4'h0;
    ilc_cause_type cause_q  = CAUSE_POR;

    // Request word, one driver, fixed return address
    assign core_req = {pulse_q[3], take_q, pulse_q[2:0], cause_q, 13'h0ABC};

    // Vector after take_lag + 1 cycles of a standing request
    always @(posedge core_clk) begin
        if (!rst_b || !irq_req || take_q) begin
            wait_cnt <= 0;
            take_q   <= 1'b0;
        end else if (wait_cnt == int'(take_lag)) begin
            take_q <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    // One-cycle instruction pulse: 8 return, 4 sleep, 2 watchdog, 1 reset
    task automatic issue(input logic [3:0] sel, input ilc_cause_type cs);
        @(posedge core_clk);
        pulse_q <= sel;
        cause_q <= cs;
        @(posedge core_clk);
        pulse_q <= 4'h0;
        #1;
    endtask : issue
endmodule : ilc_core_model

/* verif/ilc_irq_wake_bench.sv */
// Self-checking bench for the interrupt and wake logic
`timescale 1ns/1ps
module ilc_irq_wake_bench
    import ilc_pkg::*;
();
    logic             core_clk;
    logic             rst_b;
    logic [2:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    ilc_core_req_type core_req;
    ilc_core_rsp_type core_rsp;
    logic             irq_req;
    logic             wake_pulse;
    logic             asleep;
    logic             pin;
    logic [7:4]       port_b;
    logic             tick;
    logic [1:0][7:0]  evt;
    logic [3:0]       take_lag;
    int               mismatches;
    int               cmp_count;

    ilc_irq_wake u_ilc_irq_wake (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req),
        .core_rsp(core_rsp), .irq_req(irq_req), .wake_pulse(wake_pulse), .asleep(asleep),
        .external_irq_pin(pin), .port_b_pins(port_b), .timer_tick(tick), .periph_evt(evt));

    ilc_core_model u_ilc_core_model (
        .core_clk(core_clk), .rst_b(rst_b), .irq_req(irq_req),
        .take_lag(take_lag), .core_req(core_req));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Register port cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    // Wait for the core to vector, then check the answer
    task automatic wait_push();
        repeat (12) begin
            @(posedge core_clk);
            #1;
            if (core_rsp.push === 1'b1) break;
        end
        chk(core_rsp.push, 1'b1);
        chk(core_rsp.pc_val, VEC_IRQ);
        chk(core_rsp.push_val, 13'h0ABC);
    endtask : wait_push

    task automatic t_reset();
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_OPTION, 8'hFF);
        wr(ADDR_STAT, 8'hFF);
        rd_chk(ADDR_STAT, 8'h18);
        rd_chk(ADDR_TIMER, 8'h00);
    endtask : t_reset

    task automatic t_pin();
        int n;
        take_lag = 4'h3;
        wr(ADDR_CTRL, 8'h90);
        @(posedge core_clk);
        pin <= 1'b1;
        for (n = 1; n < 9; n++) begin
            @(posedge core_clk);
            #1;
            if (irq_req === 1'b1) break;
        end
        chk(16'(n), 16'h0003);
        wait_push();
        rd_chk(ADDR_CTRL, 8'h12);
        wr(ADDR_CTRL, 8'h10);
        u_ilc_core_model.issue(4'h8, CAUSE_POR);
        rd_chk(ADDR_CTRL, 8'h90);
        wr(ADDR_OPTION, 8'hBF);
        @(posedge core_clk);
        pin <= 1'b0;
        wait_push();
        wr(ADDR_CTRL, 8'h10);
        @(posedge core_clk);
        pin <= 1'b1;
        idle(5);
        rd_chk(ADDR_CTRL, 8'h10);
        wr(ADDR_OPTION, 8'hFF);
    endtask : t_pin

    task automatic t_timer();
        wr(ADDR_TIMER, 8'hFF);
        @(posedge core_clk);
        tick <= 1'b1;
        @(posedge core_clk);
        tick <= 1'b0;
        rd_chk(ADDR_TIMER, 8'h00);
        rd_chk(ADDR_CTRL, 8'h14);
        wr(ADDR_CTRL, 8'h24);
        chk(irq_req, 1'b0);
        wr(ADDR_CTRL, 8'h00);
    endtask : t_timer

    task automatic t_port();
        @(posedge core_clk);
        port_b <= 4'h2;
        idle(6);
        rd_chk(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
    endtask : t_port

    task automatic t_periph();
        take_lag = 4'h0;
        @(posedge core_clk);
        evt[1] <= 8'h08;
        @(posedge core_clk);
        evt <= '0;
        rd_chk(ADDR_REQ_B, 8'h08);
        wr(ADDR_EN_B, 8'h08);
        wr(ADDR_CTRL, 8'h80);
        chk(irq_req, 1'b0);
        wr(ADDR_CTRL, 8'hC0);
        chk(irq_req, 1'b1);
        wait_push();
        wr(ADDR_REQ_B, 8'h00);
        wr(ADDR_CTRL, 8'h00);
    endtask : t_periph

    task automatic t_sleep();
        wr(ADDR_CTRL, 8'h10);
        u_ilc_core_model.issue(4'h4, CAUSE_POR);
        chk(asleep, 1'b1);
        rd_chk(ADDR_STAT, 8'h10);
        @(posedge core_clk);
        pin <= 1'b0;
        idle(5);
        chk(asleep, 1'b1);
        @(posedge core_clk);
        pin <= 1'b1;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            if (wake_pulse === 1'b1) break;
        end
        chk({wake_pulse, asleep, irq_req}, 3'b100);
        chk(core_rsp.pc_load, 1'b0);
        rd_chk(ADDR_STAT, 8'h10);
        wr(ADDR_CTRL, 8'h00);
        u_ilc_core_model.issue(4'h4, CAUSE_POR);
        u_ilc_core_model.issue(4'h2, CAUSE_POR);
        chk(asleep, 1'b0);
        rd_chk(ADDR_STAT, 8'h00);
    endtask : t_sleep

    task automatic t_devrst();
        wr(ADDR_CTRL, 8'h80);
        u_ilc_core_model.issue(4'h1, CAUSE_EXT_RST);
        chk({core_rsp.pc_load, core_rsp.pc_val}, {1'b1, VEC_RESET});
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_STAT, 8'h00);
        u_ilc_core_model.issue(4'h1, CAUSE_DOG);
        rd_chk(ADDR_STAT, 8'h08);
        u_ilc_core_model.issue(4'h4, CAUSE_POR);
        u_ilc_core_model.issue(4'h1, CAUSE_EXT_RST);
        chk(asleep, 1'b0);
        rd_chk(ADDR_STAT, 8'h10);
        u_ilc_core_model.issue(4'h1, CAUSE_BOR);
        rd_chk(ADDR_STAT, 8'h18);
        // Second reset with the pin line and one port line sitting high
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        idle(4);
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_OPTION, 8'hFF);
    endtask : t_devrst

    // Verdict and end of run
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Watchdog against a hang
    initial begin
        #(25 * 5000);
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial begin
        mismatches = 0;
        cmp_count  = 0;
        rst_b      = 1'b0;
        reg_addr   = 3'h0;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        pin        = 1'b0;
        port_b     = 4'h0;
        tick       = 1'b0;
        evt        = '0;
        take_lag   = 4'h2;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_pin();
        t_timer();
        t_port();
        t_periph();
        t_sleep();
        t_devrst();
        wrap_up();
    end
endmodule : ilc_irq_wake_bench
